// ---- bench/serial_node.sv ----
// Remote serial node: drives the receive line and decodes the transmit line
`timescale 1ns/100ps
module serial_node (
  input wire logic mclk,
  input wire logic txLine,
  output logic rxLine
);
  // ------------
  // Line drivers
  // ------------
  initial rxLine = 1'b1;
  // start, data LSB first, stop, then one idle bit at mark
  task automatic send(input logic [8:0] d, input int nb, input logic stopBit, input int bt);
    @(posedge mclk);
    rxLine <= 1'b0;
    repeat (bt) @(posedge mclk);
    for (int i = 0; i < nb; i++) begin
      rxLine <= d[i];
      repeat (bt) @(posedge mclk);
    end
    rxLine <= stopBit;
    repeat (bt) @(posedge mclk);
    rxLine <= 1'b1;
    repeat (bt) @(posedge mclk);
  endtask : send
  // find the start edge, then sample every bit and the stop at its centre
  task automatic recv(input int nb, input int bt, output logic [9:0] d, output bit ok);
    int n;
    d = '0;
    for (n = 0; n < 40 * bt && txLine !== 1'b0; n++) begin
      @(posedge mclk);
    end
    ok = n < 40 * bt;
    if (ok) begin
      repeat (bt / 2) @(posedge mclk);
      for (int i = 0; i <= nb; i++) begin
        repeat (bt) @(posedge mclk);
        d[i] = txLine;
      end
      repeat (bt) @(posedge mclk);
    end
  endtask : recv
endmodule : serial_node

// ---- bench/tb.sv ----
// Self-checking bench for the serial port block
`timescale 1ns/100ps
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin errors++; \
  $display("mismatch %0t got %h want %h", $time, g, e); end end
module tb;
  import uart_pkg::*;
  logic mclk;
  logic nrst;
  wb_req_s wbReq;
  logic [31:0] wbDatO;
  logic wbAck;
  logic serialTx;
  logic serialRx;
  logic txIrq;
  logic rxIrq;
  int errors;
  int comparisons;
  int bt;
  bit ok;
  logic [15:0] seed;
  logic [12:0] dv;
  logic [9:0] f;
  logic [7:0] q;
  logic [7:0] b;
  logic [7:0] modes [3] = '{8'h80, 8'hC0, 8'hE0};
  // ------------------
  // Design and partner
  // ------------------
  uart_baud_autobaud_config i_uart_baud_autobaud_config (.mclk(mclk), .nrst(nrst), .wbReq(wbReq),
    .wbDatO(wbDatO), .wbAck(wbAck), .serialTx(serialTx), .serialRx(serialRx), .txIrq(txIrq), .rxIrq(rxIrq));
  serial_node i_serial_node (.mclk(mclk), .txLine(serialTx), .rxLine(serialRx));
  always #5 mclk = ~mclk;
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : lfsr
  // Clocks per bit for a divisor
  function automatic int bitTime(input logic [12:0] d);
    return 4 * (int'(d) + 1);
  endfunction : bitTime
  // Small divisors keep the run short
  task automatic draw();
    seed = lfsr(seed);
    b = seed[7:0];
    dv = 13'(seed[10:8]) + 13'h0003;
  endtask : draw
  task automatic finish_test();
    $display("errors %0d comparisons %0d", errors, comparisons);
    if (errors == 0 && comparisons > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : finish_test
  // Classic cycle; held until ack is seen, data taken at that edge
  task automatic wb(input logic w, input logic [3:0] a, input logic [7:0] d, output logic [7:0] r);
    int n;
    @(posedge mclk);
    wbReq <= '{1'b1, 1'b1, w, 4'hF, a, {24'h0, d}};
    n = 0;
    // Ack is sampled at rising edges only; data is taken and the request dropped there
    do begin
      @(posedge mclk);
      n++;
    end while (wbAck !== 1'b1 && n < 20);
    r = wbDatO[7:0];
    wbReq <= '0;
    if (wbAck !== 1'b1) begin
      errors++;
      finish_test();
    end
  endtask : wb
  // Main sequence
  initial begin
    errors = 0;
    comparisons = 0;
    mclk = 1'b0;
    nrst = 1'b0;
    wbReq = '0;
    seed = 16'h390E;
    repeat (20) @(posedge mclk);
    nrst <= 1'b1;
    wb(1'b0, IDX_INT_CTRL, 8'h00, q);
    `CHK(q[IC_TX_FLAG], 1'b1)
    wb(1'b0, 4'hF, 8'h00, q);
    `CHK(q, 8'h00)
    wb(1'b1, IDX_INT_CTRL, 8'hE0, q);
    `CHK({txIrq, rxIrq}, 2'b10)
    draw();
    bt = bitTime(dv);
    wb(1'b1, IDX_DIV_LOW, dv[7:0], q);
    wb(1'b0, IDX_DIV_LOW, 8'h00, q);
    `CHK(q, dv[7:0])
    for (int k = 0; k < 4; k++) begin
      draw();
      wb(1'b1, IDX_CONTROL, {2'b11, k[1:0], 4'h0}, q);
      wb(1'b1, IDX_TX_BUF, b, q);
      i_serial_node.recv(8 + k[1], bt, f, ok);
      `CHK({ok, f}, {1'b1, k[1] ? {1'b1, k[0], b} : {2'b01, b}})
    end
    wb(1'b1, IDX_CONTROL, 8'h40, q);
    wb(1'b1, IDX_TX_BUF, b, q);
    i_serial_node.recv(8, bt, f, ok);
    `CHK(ok, 1'b0)
    wb(1'b1, IDX_CONTROL, 8'h80, q);
    for (int k = 0; k < 3; k++) begin
      draw();
      wb(1'b1, IDX_BAUD_CTRL, modes[k], q);
      i_serial_node.send({1'b1, b}, 8 + int'(k > 0), 1'b1, bt);
      `CHK(rxIrq, 1'b1)
      wb(1'b0, IDX_STATUS, 8'h00, q);
      `CHK(q[STA_RX_NINTH] | (k == 0), 1'b1)
      wb(1'b0, IDX_RX_BUF, 8'h00, q);
      `CHK({q, rxIrq}, {b, 1'b0})
    end
    // nine-bit mode and address detect dropped so 8-bit frames arrive as data
    wb(1'b1, IDX_BAUD_CTRL, 8'h80, q);
    i_serial_node.send({1'b0, b}, 8, 1'b0, bt);
    wb(1'b0, IDX_STATUS, 8'h00, q);
    `CHK(q[STA_FRAME_ERR], 1'b1)
    wb(1'b1, IDX_BAUD_CTRL, 8'h00, q);
    wb(1'b0, IDX_STATUS, 8'h00, q);
    `CHK(q[STA_FRAME_ERR], 1'b0)
    wb(1'b1, IDX_BAUD_CTRL, 8'h80, q);
    // Empty the buffer left by the bad frame, so only the second byte overruns
    wb(1'b0, IDX_RX_BUF, 8'h00, q);
    i_serial_node.send({1'b0, b}, 8, 1'b1, bt);
    wb(1'b0, IDX_STATUS, 8'h00, q);
    `CHK({q[STA_FRAME_ERR], q[STA_OVERRUN]}, 2'b00)
    i_serial_node.send({1'b0, b}, 8, 1'b1, bt);
    wb(1'b0, IDX_STATUS, 8'h00, q);
    `CHK(q[STA_OVERRUN], 1'b1)
    wb(1'b0, IDX_RX_BUF, 8'h00, q);
    draw();
    wb(1'b1, IDX_BAUD_CTRL, 8'h90, q);
    i_serial_node.send(9'h055, 8, 1'b1, bitTime(dv));
    wb(1'b0, IDX_DIV_LOW, 8'h00, q);
    `CHK(q, dv[7:0])
    wb(1'b0, IDX_DIV_HIGH, 8'h00, q);
    `CHK(q[4:0], 5'h00)
    wb(1'b0, IDX_STATUS, 8'h00, q);
    `CHK(q[STA_ABD_OVF], 1'b0)
    finish_test();
  end
endmodule : tb

// ---- bench/uart_sva.sv ----
// Checker for bus handshake and serial line timing of the serial port
`timescale 1ns/100ps
module uart_sva
  import uart_pkg::*;
(
  input wire logic mclk,
  input wire logic nrst,
  input wire uart_pkg::wb_req_s wbReq,
  input wire logic [31:0] wbDatO,
  input wire logic wbAck,
  input wire logic serialTx,
  input wire logic serialRx,
  input wire logic txIrq,
  input wire logic rxIrq
);
  // ----------
  // Properties
  // ----------
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!nrst);
  // Request present and not yet answered
  sequence sTaken;
    wbReq.cyc && wbReq.stb && !wbAck;
  endsequence
  // Shortest bit is four clocks, so a level holds three more
  sequence sHeld;
    ##1 $stable(serialTx) [*3];
  endsequence
  chk_ack_next: assert property (sTaken |=> wbAck) else $error("ack missing");
  chk_ack_pulse: assert property (wbAck |=> !wbAck) else $error("ack too long");
  chk_ack_cause: assert property (!(wbReq.cyc && wbReq.stb) |=> !wbAck) else $error("ack alone");
  chk_dat_upper: assert property (wbAck |-> wbDatO[31:8] == 24'h0) else $error("upper data set");
  chk_bit_min: assert property ($changed(serialTx) |-> sHeld) else $error("bit too short");
  chk_tx_idle: assert property ($rose(nrst) |-> serialTx) else $error("line not idle");
  chk_irq_reset: assert property ($rose(nrst) |-> !txIrq && !rxIrq) else $error("irq at reset");
  chk_rx_clear: assert property ($fell(rxIrq) |-> wbAck || $past(wbAck)) else $error("rx irq fell");
endmodule : uart_sva

bind uart_baud_autobaud_config uart_sva i_uart_sva (.mclk(mclk), .nrst(nrst), .wbReq(wbReq),
  .wbDatO(wbDatO), .wbAck(wbAck), .serialTx(serialTx), .serialRx(serialRx), .txIrq(txIrq), .rxIrq(rxIrq));

// ---- design/uart_baud_autobaud_config.sv ----
// Serial port with baud generator, automatic baud detection and register file
// Functional notes
// - Thirteen-bit baud divisor runs independent timer
// - Bit rate is clock over 4(n+1)
// - Receive pin sampled at bit centre
// - Autobaud needs wakeup off, autobaud on
// - Start edge begins measurement of 055H
// - Measured divisor written to divisor registers
// - Measurement counter wrap sets overflow flag
// - Overflow cleared by writing zero or disabling
// - Overflow leaves autobaud enable set
// - Transmit empty flag high after reset
// - Interrupts gated by own and global enable
// - Serial enable gates transmit and receive
// - Nine-bit transmit sends ninth-bit control
// - Buffer write with transmit enable starts sending
// - Ninth received bit goes to status
// - Clearing receive enable clears framing error
// - Address detect mode sets receive-complete flag
// - Software clears address detect after address
// - Bad stop bit flags framing error
// - Unread byte overwritten flags overrun
// - Frame: start, 8 or 9 bits, stop
// - LSB first, shared format and rate
//
// The address map and the Wishbone interface to the registers were decided locally.
`timescale 1ns/100ps
module uart_baud_autobaud_config
  import uart_pkg::*;
#(
  parameter int DIVW = 13
) (
  input wire logic mclk,
  input wire logic nrst,
  input wire uart_pkg::wb_req_s wbReq,
  output logic [31:0] wbDatO,
  output logic wbAck,
  output logic serialTx,
  input wire logic serialRx,
  output logic txIrq,
  output logic rxIrq
);

  // ------------------------------------------------------------
  // Parameter check
  // ------------------------------------------------------------
  // Field positions and the autobaud scaling are fixed to a 13-bit divisor
  if (DIVW != DIV_WIDTH) begin : g_bad_divw
    $error("Divisor width must be 13");
  end

  // ------------------------------------------------------------
  // State
  // ------------------------------------------------------------
  typedef enum logic [1:0] {TX_IDLE, TX_SHIFT} tx_e;
  typedef enum logic [1:0] {RX_IDLE, RX_SHIFT, RX_ABD} rx_e;

  typedef struct packed {
    logic ack;
    logic [31:0] rdata;
    logic [7:0] ctl;
    logic [7:0] bc;
    logic [2:0] ie;
    logic [12:0] divisor;
    logic [12:0] divCnt;
    logic [1:0] rxSync;
    logic rxPrev;
    tx_e txState;
    logic [7:0] txBuf;
    logic txFull;
    logic [9:0] txShift;
    logic [3:0] txBits;
    logic [1:0] txPh;
    logic txLine;
    logic txFlag;
    rx_e rxState;
    logic [1:0] rxPh;
    logic [3:0] rxBits;
    logic [8:0] rxShift;
    logic [7:0] rxBuf;
    logic rxNinth;
    logic rxFull;
    logic parErr;
    logic frameErr;
    logic overrun;
    logic autobaud_overflow_flag;
    // Eight bit times are 32 counts per divisor unit; 18 bits hold 8192 units
    logic [17:0] abdCnt;
    logic [3:0] abdEdges;
  } state_s;

  state_s r, nx;
  logic tick;
  logic wr, rd;

  // Four sub-ticks per bit, each after divisor+1 clocks
  function automatic logic div_tick(input logic [12:0] cnt);
    return cnt == 13'h0000;
  endfunction : div_tick

  // ------------------------------------------------------------
  // Bus decode
  // ------------------------------------------------------------
  // A request is taken once; the cycle that carries ack never acts again
  assign wr = wbReq.cyc & wbReq.stb & wbReq.we & ~r.ack;
  assign rd = wbReq.cyc & wbReq.stb & ~wbReq.we & ~r.ack;
  assign tick = div_tick(r.divCnt);

  // ------------------------------------------------------------
  // Next-state logic
  // ------------------------------------------------------------
  always_comb begin
    logic serEn;
    logic rxBit;
    logic lastBit;
    logic rxDone;
    logic ovfSet;
    serEn = 1'b0;
    rxBit = 1'b0;
    lastBit = 1'b0;
    // Set events of this cycle, so that a software clear cannot swallow them
    rxDone = 1'b0;
    ovfSet = 1'b0;
    nx = r;
    serEn = r.ctl[CTL_SERIAL_EN];
    rxBit = r.rxSync[1];
    nx.ack = (wbReq.cyc & wbReq.stb) & ~r.ack;
    nx.rxSync = {r.rxSync[0], serialRx};
    nx.rxPrev = rxBit;

    if (tick) begin
      nx.divCnt = r.divisor;
    end else begin
      nx.divCnt = r.divCnt - 13'h0001;
    end

    // Transmitter
    // serial enable gates transmit
    case (r.txState)
      TX_IDLE: begin
        nx.txLine = 1'b1;
        if (r.txFull && serEn && r.ctl[CTL_TX_EN]) begin
          // ninth bit taken from the control register
          nx.txShift = {1'b1, r.ctl[CTL_TX_NINTH], r.txBuf};
          nx.txBits = r.ctl[CTL_TX_NINE] ? 4'hA : 4'h9;
          nx.txLine = 1'b0;
          nx.txPh = 2'h0;
          nx.txFull = 1'b0;
          nx.txState = TX_SHIFT;
          if (!r.ctl[CTL_TX_NINE]) begin
            nx.txShift = {1'b1, 1'b1, r.txBuf};
          end
        end
      end
      TX_SHIFT: begin
        if (tick) begin
          nx.txPh = r.txPh + 2'h1;
          if (r.txPh == 2'h3) begin
            if (r.txBits == 4'h0) begin
              nx.txState = TX_IDLE;
              nx.txLine = 1'b1;
            end else begin
              nx.txLine = r.txShift[0];
              nx.txShift = {1'b1, r.txShift[9:1]};
              nx.txBits = r.txBits - 4'h1;
            end
          end
        end
      end
      default: nx.txState = TX_IDLE;
    endcase
    nx.txFlag = ~nx.txFull;

    // Receiver and autobaud
    // Count 0 is the start bit, so the stop bit follows 8 or 9 data samples
    lastBit = r.bc[BC_RX_NINE] ? (r.rxBits == 4'hA) : (r.rxBits == 4'h9);
    case (r.rxState)
      RX_IDLE: begin
        if (serEn && r.bc[BC_RX_EN] && r.rxPrev && !rxBit) begin
          if (r.bc[BC_AUTOBAUD] && !r.bc[BC_WAKEUP]) begin
            nx.rxState = RX_ABD;
            nx.abdCnt = 16'h0000;
            nx.abdEdges = 4'h0;
          end else begin
            nx.rxState = RX_SHIFT;
            nx.rxPh = 2'h0;
            nx.rxBits = 4'h0;
          end
        end
      end
      RX_SHIFT: begin
        if (tick) begin
          nx.rxPh = r.rxPh + 2'h1;
          if (r.rxPh == 2'h1) begin
            nx.rxBits = r.rxBits + 4'h1;
            if (r.rxBits == 4'h0) begin
              if (rxBit) nx.rxState = RX_IDLE;
            end else if (lastBit) begin
              nx.rxState = RX_IDLE;
              nx.frameErr = ~rxBit;
              if (r.rxFull) nx.overrun = 1'b1;
              // ninth bit to status
              // Nine-bit frames leave the data byte one place lower in the shifter
              nx.rxBuf = r.bc[BC_RX_NINE] ? r.rxShift[7:0] : r.rxShift[8:1];
              nx.rxNinth = r.bc[BC_RX_NINE] ? r.rxShift[8] : 1'b0;
              // with address detect off the ninth bit is judged as parity
              nx.parErr = r.bc[BC_RX_NINE] & ~r.bc[BC_ADDR_DET] &
                          (^r.rxShift[8:0]);
              nx.rxFull = 1'b1;
              rxDone = 1'b1;
            end else begin
              nx.rxShift = {rxBit, r.rxShift[8:1]};
            end
          end
        end
      end
      RX_ABD: begin
        // count clocks over the calibration character
        nx.abdCnt = r.abdCnt + 18'h00001;
        // wrap of the 13-bit measurement
        // In divisor units the count wraps from 1FFF to 0 as all 18 bits roll over
        if (r.abdCnt == 18'h3FFFF) begin
          ovfSet = 1'b1;
          nx.autobaud_overflow_flag = 1'b1;
        end
        if (r.rxPrev != rxBit) begin
          nx.abdEdges = r.abdEdges + 4'h1;
        end
        // Eighth edge after the start edge: the fall into the last data bit of 055H,
        // eight bit times on; both edges pass the same synchroniser delay
        if (r.rxPrev != rxBit && r.abdEdges == 4'h7) begin
          nx.rxState = RX_IDLE;
          // result into divisor, scaled by 4*8
          nx.divisor = nx.abdCnt[17:5] - 13'h0001;
          nx.divCnt = nx.divisor;
        end
        if (!r.bc[BC_AUTOBAUD]) nx.rxState = RX_IDLE;
      end
      default: nx.rxState = RX_IDLE;
    endcase

    // Register writes
    if (wr) begin
      case (wbReq.adr)
        IDX_CONTROL: nx.ctl = wbReq.dat[7:0];
        IDX_BAUD_CTRL: begin
          nx.bc = wbReq.dat[7:0];
          // clearing receive enable clears framing and overrun errors
          // An error raised by a frame ending in this very cycle survives the clear
          if (!wbReq.dat[BC_RX_EN]) begin
            nx.frameErr = rxDone & ~rxBit;
            nx.overrun = rxDone & r.rxFull;
          end
          if (!wbReq.dat[BC_AUTOBAUD]) nx.autobaud_overflow_flag = ovfSet;
        end
        IDX_STATUS: begin
          // enable untouched by the flag
          // A wrap in the same cycle wins over the clear
          if (!wbReq.dat[STA_ABD_OVF]) nx.autobaud_overflow_flag = ovfSet;
        end
        IDX_DIV_HIGH: begin
          nx.divisor = {wbReq.dat[4:0], r.divisor[7:0]};
          nx.divCnt = nx.divisor;
        end
        IDX_DIV_LOW: begin
          nx.divisor = {r.divisor[12:8], wbReq.dat[7:0]};
          nx.divCnt = nx.divisor;
        end
        IDX_TX_BUF: begin
          nx.txBuf = wbReq.dat[7:0];
          nx.txFull = 1'b1;
          nx.txFlag = 1'b0;
        end
        IDX_INT_CTRL: nx.ie = wbReq.dat[7:5];
        default: ;
      endcase
    end

    // Reads; receive buffer read releases the complete flag
    nx.rdata = 32'h0000_0000;
    if (rd) begin
      case (wbReq.adr)
        IDX_CONTROL: nx.rdata[7:0] = r.ctl;
        IDX_STATUS: nx.rdata[7:0] = {r.rxNinth, r.parErr, r.frameErr, r.overrun,
                                     (r.rxState == RX_IDLE), (r.txState == TX_IDLE) & ~r.txFull,
                                     r.autobaud_overflow_flag, 1'b0};
        IDX_BAUD_CTRL: nx.rdata[7:0] = r.bc;
        IDX_DIV_HIGH: nx.rdata[7:0] = {3'h0, r.divisor[12:8]};
        IDX_DIV_LOW: nx.rdata[7:0] = r.divisor[7:0];
        IDX_TX_BUF: nx.rdata[7:0] = r.txBuf;
        IDX_RX_BUF: begin
          nx.rdata[7:0] = r.rxBuf;
          // New byte in the same cycle wins over the read clear
          nx.rxFull = rxDone;
        end
        IDX_INT_CTRL: nx.rdata[7:0] = {r.ie, 3'h0, r.txFlag, r.rxFull};
        default: nx.rdata = 32'h0000_0000;
      endcase
    end
  end

  // ------------------------------------------------------------
  // State register
  // ------------------------------------------------------------
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      r <= '0;
      r.divisor <= DIVISOR_RESET;
      r.rxSync <= 2'h3;
      r.rxPrev <= 1'b1;
      r.txLine <= 1'b1;
      // transmit empty flag high after reset
      r.txFlag <= 1'b1;
      r.txState <= TX_IDLE;
      r.rxState <= RX_IDLE;
    end else begin
      r <= nx;
    end
  end

  // ------------------------------------------------------------
  // Outputs
  // ------------------------------------------------------------
  // Bus and serial outputs come straight from the state register; the interrupts are ANDs of register bits
  assign wbAck = r.ack;
  assign wbDatO = r.rdata;
  assign serialTx = r.txLine;
  // gated by own and global enable
  assign txIrq = r.ie[2] & r.ie[1] & r.txFlag;
  assign rxIrq = r.ie[2] & r.ie[0] & r.rxFull;

endmodule : uart_baud_autobaud_config

// ---- shared/uart_pkg.sv ----
// Package with register map, field positions and timing constants of the serial port
package uart_pkg;

  // ------------------------------------------------------------
  // Register indices (byte address is four times the index)
  // ------------------------------------------------------------
  localparam logic [3:0] IDX_CONTROL = 4'h0;
  localparam logic [3:0] IDX_STATUS = 4'h1;
  localparam logic [3:0] IDX_BAUD_CTRL = 4'h2;
  localparam logic [3:0] IDX_DIV_HIGH = 4'h3;
  localparam logic [3:0] IDX_DIV_LOW = 4'h4;
  localparam logic [3:0] IDX_TX_BUF = 4'h5;
  localparam logic [3:0] IDX_RX_BUF = 4'h6;
  localparam logic [3:0] IDX_INT_CTRL = 4'h7;

  // ------------------------------------------------------------
  // Field positions
  // ------------------------------------------------------------
  // Control register
  localparam int CTL_SERIAL_EN = 7;
  localparam int CTL_TX_EN = 6;
  localparam int CTL_TX_NINE = 5;
  localparam int CTL_TX_NINTH = 4;
  // Status register
  localparam int STA_RX_NINTH = 7;
  localparam int STA_PARITY_ERR = 6;
  localparam int STA_FRAME_ERR = 5;
  localparam int STA_OVERRUN = 4;
  localparam int STA_RX_IDLE = 3;
  localparam int STA_SHIFT_EMPTY = 2;
  localparam int STA_ABD_OVF = 1;
  // Receive and baud control register
  localparam int BC_RX_EN = 7;
  localparam int BC_RX_NINE = 6;
  localparam int BC_ADDR_DET = 5;
  localparam int BC_AUTOBAUD = 4;
  localparam int BC_WAKEUP = 3;
  // Interrupt control register
  localparam int IC_GLOBAL_EN = 7;
  localparam int IC_TX_IE = 6;
  localparam int IC_RX_IE = 5;
  localparam int IC_TX_FLAG = 1;
  localparam int IC_RX_FLAG = 0;

  // ------------------------------------------------------------
  // Reset values and counts
  // ------------------------------------------------------------
  localparam logic [12:0] DIVISOR_RESET = 13'h0000;
  localparam int DIV_WIDTH = 13;
  localparam int TICKS_PER_BIT = 4;
  localparam int AUTOBAUD_BITS = 8;

  // Bus request carried as one group
  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [3:0] sel;
    logic [3:0] adr;
    logic [31:0] dat;
  } wb_req_s;

endpackage : uart_pkg
